// ---- src/csw_pkg.sv ----
package csw_pkg;

	// coprocessor register number and selects of the two setup words
	localparam logic [4:0]  SETUP_REG_NUM      = 5'h10;
	localparam logic [2:0]  SEL_WORD0          = 3'h0;
	localparam logic [2:0]  SEL_WORD3          = 3'h3;

	localparam int unsigned FIELD_W            = 3;

	// setup word 0 field positions
	localparam int unsigned W0_NEXT_WORD_BIT   = 31;
	localparam int unsigned W0_KHIGH_LSB       = 28;
	localparam int unsigned W0_USER_LSB        = 25;
	localparam int unsigned W0_CUSTOM_BIT      = 22;
	localparam int unsigned W0_SIMPLE_BIT      = 21;
	localparam int unsigned W0_MULDIV_BIT      = 20;
	localparam int unsigned W0_DUAL_SRAM_BIT   = 16;
	localparam int unsigned W0_ORDER_BIT       = 15;
	localparam int unsigned W0_FAMILY_LSB      = 13;
	localparam int unsigned W0_RELEASE_LSB     = 10;
	localparam int unsigned W0_MAPPING_LSB     = 7;
	localparam int unsigned W0_KZERO_LSB       = 0;
	localparam logic [31:0] W0_RESERVED_MASK   = 32'h018e0078;

	// setup word 3 field positions
	localparam int unsigned W3_PRIO_WIDTH_LSB  = 21;
	localparam int unsigned W3_COMPACT_REL_LSB = 18;
	localparam int unsigned W3_MCU_EXT_BIT     = 17;
	localparam int unsigned W3_EXC_SET_BIT     = 16;
	localparam int unsigned W3_ISA_LSB         = 14;
	localparam int unsigned W3_USER_LOCAL_BIT  = 13;
	localparam int unsigned W3_INHIBIT_BIT     = 12;
	localparam int unsigned W3_INSTR_TRACE_BIT = 8;
	localparam int unsigned W3_EXT_IRQ_BIT     = 6;
	localparam int unsigned W3_VEC_IRQ_BIT     = 5;
	localparam int unsigned W3_SMALL_PAGE_BIT  = 4;
	localparam int unsigned W3_DEV_MAP_BIT     = 3;
	localparam int unsigned W3_TRACE_BIT       = 0;
	localparam logic [31:0] W3_UNIMPL_MASK     = 32'hff800e86;

	// field codes
	localparam logic [2:0]  NO_CACHE_CODE      = 3'h2;
	localparam logic [2:0]  FIXED_MAP_CODE     = 3'h3;
	localparam logic [1:0]  PRIO_WIDTH_8BIT    = 2'h1;
	localparam logic [1:0]  ISA_COMPACT_ONLY   = 2'h1;

	// values after reset
	localparam logic [2:0]  KHIGH_RESET        = 3'h2;
	localparam logic [2:0]  USER_RESET         = 3'h2;
	localparam logic [2:0]  KZERO_RESET        = 3'h2;
	localparam logic [31:0] RDATA_RESET        = 32'h00000000;

endpackage : csw_pkg

// ---- src/csw_field_if.sv ----
`timescale 1ns/1ps
interface csw_field_if #(
	parameter int W = 3
);
	logic         wr;
	logic [W-1:0] wdata;
	logic [W-1:0] value;

	modport ctrl (output wr, output wdata, input value);
	modport store (input wr, input wdata, output value);
endinterface : csw_field_if

// ---- src/csw_field.sv ----
`timescale 1ns/1ps
module csw_field #(
	parameter int              W           = 3,
	parameter logic [W-1:0]    RESET_VALUE = '0
) (
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	input  wire logic          clk_en,
	csw_field_if.store         port
);

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			port.value <= RESET_VALUE;
		end else if (clk_en && port.wr) begin
			port.value <= port.wdata;
		end
	end

endmodule : csw_field

// ---- src/csw_bank.sv ----
`timescale 1ns/1ps
module csw_bank #(
	// identification values: arbitrary neutral defaults
	parameter logic [1:0] CORE_FAMILY_KIND     = 2'h2,
	parameter logic [2:0] CORE_RELEASE_LEVEL   = 3'h5,
	parameter logic [2:0] COMPACT_CODE_RELEASE = 3'h6
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        clk_en,
	input  wire logic        cp0_rd_en,
	input  wire logic        cp0_wr_en,
	input  wire logic [4:0]  cp0_reg_num,
	input  wire logic [2:0]  cp0_sel,
	input  wire logic [31:0] cp0_wdata,
	output logic      [31:0] cp0_rdata,
	output logic             cp0_rvalid,
	output logic             cp0_rhit,
	output logic      [2:0]  kernel_high_seg_cacheability,
	output logic      [2:0]  user_seg_cacheability,
	output logic      [2:0]  kernel_seg_zero_policy
);

	localparam int FW = csw_pkg::FIELD_W;

	logic        hit_word0;
	logic        hit_word3;
	logic        wr_word0;
	logic [31:0] core_setup_word0;
	logic [31:0] core_setup_word3;
	logic [31:0] next_rdata;
	logic        word0_written;

	csw_field_if #(.W(FW)) khigh_if ();
	csw_field_if #(.W(FW)) user_if ();
	csw_field_if #(.W(FW)) kzero_if ();

	assign hit_word0 = (cp0_reg_num == csw_pkg::SETUP_REG_NUM)
		&& (cp0_sel == csw_pkg::SEL_WORD0);
	assign hit_word3 = (cp0_reg_num == csw_pkg::SETUP_REG_NUM)
		&& (cp0_sel == csw_pkg::SEL_WORD3);
	// writes to word3 or other selects fall through with no effect
	assign wr_word0 = cp0_wr_en && hit_word0;

	// reserved bits of the write data are simply not routed anywhere
	assign khigh_if.wr    = wr_word0;
	assign khigh_if.wdata = cp0_wdata[csw_pkg::W0_KHIGH_LSB +: FW];
	assign user_if.wr     = wr_word0;
	assign user_if.wdata  = cp0_wdata[csw_pkg::W0_USER_LSB +: FW];
	assign kzero_if.wr    = wr_word0;
	assign kzero_if.wdata = cp0_wdata[csw_pkg::W0_KZERO_LSB +: FW];

	csw_field #(.W(FW), .RESET_VALUE(csw_pkg::KHIGH_RESET)) u_khigh (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.port    (khigh_if.store)
	);

	csw_field #(.W(FW), .RESET_VALUE(csw_pkg::USER_RESET)) u_user (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.port    (user_if.store)
	);

	csw_field #(.W(FW), .RESET_VALUE(csw_pkg::KZERO_RESET)) u_kzero (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.clk_en  (clk_en),
		.port    (kzero_if.store)
	);

	assign kernel_high_seg_cacheability = khigh_if.value;
	assign user_seg_cacheability        = user_if.value;
	assign kernel_seg_zero_policy       = kzero_if.value;

	always_comb begin
		core_setup_word0 = '0;
		core_setup_word0[csw_pkg::W0_NEXT_WORD_BIT] = 1'b1;
		core_setup_word0[csw_pkg::W0_KHIGH_LSB +: FW] = khigh_if.value;
		core_setup_word0[csw_pkg::W0_USER_LSB +: FW] = user_if.value;
		core_setup_word0[csw_pkg::W0_CUSTOM_BIT] = 1'b0;
		core_setup_word0[csw_pkg::W0_SIMPLE_BIT] = 1'b1;
		core_setup_word0[csw_pkg::W0_MULDIV_BIT] = 1'b0;
		core_setup_word0[csw_pkg::W0_DUAL_SRAM_BIT] = 1'b1;
		// little-endian core
		core_setup_word0[csw_pkg::W0_ORDER_BIT] = 1'b0;
		core_setup_word0[csw_pkg::W0_FAMILY_LSB +: 2] = CORE_FAMILY_KIND;
		core_setup_word0[csw_pkg::W0_RELEASE_LSB +: 3] = CORE_RELEASE_LEVEL;
		core_setup_word0[csw_pkg::W0_MAPPING_LSB +: 3] =
			csw_pkg::FIXED_MAP_CODE;
		core_setup_word0[csw_pkg::W0_KZERO_LSB +: FW] = kzero_if.value;
	end

	always_comb begin
		core_setup_word3 = '0;
		core_setup_word3[csw_pkg::W3_PRIO_WIDTH_LSB +: 2] =
			csw_pkg::PRIO_WIDTH_8BIT;
		core_setup_word3[csw_pkg::W3_COMPACT_REL_LSB +: 3] =
			COMPACT_CODE_RELEASE;
		core_setup_word3[csw_pkg::W3_MCU_EXT_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_EXC_SET_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_ISA_LSB +: 2] =
			csw_pkg::ISA_COMPACT_ONLY;
		core_setup_word3[csw_pkg::W3_USER_LOCAL_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_INHIBIT_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_INSTR_TRACE_BIT] = 1'b0;
		core_setup_word3[csw_pkg::W3_EXT_IRQ_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_VEC_IRQ_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_SMALL_PAGE_BIT] = 1'b0;
		core_setup_word3[csw_pkg::W3_DEV_MAP_BIT] = 1'b1;
		core_setup_word3[csw_pkg::W3_TRACE_BIT] = 1'b0;
	end

	// a read in the same cycle as a write returns the old word
	always_comb begin
		if (hit_word0) begin
			next_rdata = core_setup_word0;
		end else if (hit_word3) begin
			next_rdata = core_setup_word3;
		end else begin
			next_rdata = csw_pkg::RDATA_RESET;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cp0_rdata <= csw_pkg::RDATA_RESET;
			cp0_rhit  <= 1'b0;
		end else if (clk_en && cp0_rd_en) begin
			cp0_rdata <= next_rdata;
			cp0_rhit  <= hit_word0 || hit_word3;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cp0_rvalid <= 1'b0;
		end else if (clk_en) begin
			cp0_rvalid <= cp0_rd_en;
		end
	end

	// helper for the checks: high once word0 has been written since reset
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			word0_written <= 1'b0;
		end else if (clk_en && wr_word0) begin
			word0_written <= 1'b1;
		end
	end

	logic rd0_take;
	logic rd3_take;
	logic wr0_take;
	assign rd0_take = clk_en && cp0_rd_en && hit_word0;
	assign rd3_take = clk_en && cp0_rd_en && hit_word3;
	assign wr0_take = clk_en && wr_word0;

	next_word_bit_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd0_take |=> cp0_rvalid && cp0_rhit
			&& cp0_rdata[csw_pkg::W0_NEXT_WORD_BIT])
		else $error("word0 next-word bit not set");

	khigh_reset_code_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(rd0_take && !word0_written) |=>
			cp0_rdata[csw_pkg::W0_KHIGH_LSB +: 3] == csw_pkg::NO_CACHE_CODE)
		else $error("high kernel cacheability not no-cache");

	user_reset_code_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(rd0_take && !word0_written) |=>
			cp0_rdata[csw_pkg::W0_USER_LSB +: 3] == csw_pkg::NO_CACHE_CODE)
		else $error("user cacheability not no-cache");

	kzero_reset_code_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(rd0_take && !word0_written) |=>
			cp0_rdata[csw_pkg::W0_KZERO_LSB +: 3] == csw_pkg::NO_CACHE_CODE)
		else $error("kernel segment zero policy not no-cache");

	reserved_zero_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd0_take |=> (cp0_rdata & csw_pkg::W0_RESERVED_MASK) == 32'h00000000)
		else $error("word0 reserved bits not zero");

	fixed_flags_w0_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd0_take |=> !cp0_rdata[csw_pkg::W0_CUSTOM_BIT]
			&& !cp0_rdata[csw_pkg::W0_MULDIV_BIT])
		else $error("custom or multiply flag wrong");

	bus_sram_flags_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd0_take |=> cp0_rdata[csw_pkg::W0_SIMPLE_BIT]
			&& cp0_rdata[csw_pkg::W0_DUAL_SRAM_BIT])
		else $error("simple byte enable or dual sram flag wrong");

	ident_fields_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd0_take |=>
			cp0_rdata[csw_pkg::W0_FAMILY_LSB +: 2] == CORE_FAMILY_KIND
			&& cp0_rdata[csw_pkg::W0_RELEASE_LSB +: 3] == CORE_RELEASE_LEVEL
			&& cp0_rdata[csw_pkg::W0_MAPPING_LSB +: 3]
				== csw_pkg::FIXED_MAP_CODE)
		else $error("word0 identification fields wrong");

	word3_high_zero_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd3_take |=> cp0_rvalid
			&& (cp0_rdata & csw_pkg::W3_UNIMPL_MASK) == 32'h00000000)
		else $error("word3 unimplemented bits not zero");

	word3_codes_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd3_take |=>
			cp0_rdata[csw_pkg::W3_PRIO_WIDTH_LSB +: 2]
				== csw_pkg::PRIO_WIDTH_8BIT
			&& cp0_rdata[csw_pkg::W3_ISA_LSB +: 2]
				== csw_pkg::ISA_COMPACT_ONLY)
		else $error("word3 width or instruction set code wrong");

	word3_present_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd3_take |=> cp0_rdata[csw_pkg::W3_MCU_EXT_BIT]
			&& cp0_rdata[csw_pkg::W3_EXC_SET_BIT]
			&& cp0_rdata[csw_pkg::W3_USER_LOCAL_BIT]
			&& cp0_rdata[csw_pkg::W3_INHIBIT_BIT])
		else $error("word3 feature present flags wrong");

	word3_irq_page_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd3_take |=> cp0_rdata[csw_pkg::W3_EXT_IRQ_BIT]
			&& cp0_rdata[csw_pkg::W3_VEC_IRQ_BIT]
			&& !cp0_rdata[csw_pkg::W3_SMALL_PAGE_BIT])
		else $error("word3 interrupt or page flags wrong");

	word3_trace_map_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		rd3_take |=> cp0_rdata[csw_pkg::W3_DEV_MAP_BIT]
			&& !cp0_rdata[csw_pkg::W3_INSTR_TRACE_BIT]
			&& !cp0_rdata[csw_pkg::W3_TRACE_BIT])
		else $error("word3 map or trace flags wrong");

	field_store_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		(wr0_take && !cp0_rd_en) ##1 rd0_take |=>
			cp0_rdata[csw_pkg::W0_KHIGH_LSB +: 3]
				== $past(cp0_wdata[csw_pkg::W0_KHIGH_LSB +: 3], 2)
			&& cp0_rdata[csw_pkg::W0_KZERO_LSB +: 3]
				== $past(cp0_wdata[csw_pkg::W0_KZERO_LSB +: 3], 2)
			&& cp0_rdata[csw_pkg::W0_MAPPING_LSB +: 3]
				== csw_pkg::FIXED_MAP_CODE)
		else $error("writable field not stored or fixed field changed");

	frozen_hold_a: assert property (
		@(posedge clk_sys) disable iff (!reset_n)
		!clk_en |=> $stable(kernel_seg_zero_policy) && $stable(cp0_rdata))
		else $error("state changed while clock enable low");

endmodule : csw_bank

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	// identification values: arbitrary, chosen only to differ from defaults
	localparam logic [1:0] FAM = 2'h1;
	localparam logic [2:0] REL = 3'h3;
	localparam logic [2:0] CMP = 3'h4;

	logic        clk_sys;
	logic        reset_n;
	logic        clk_en;
	logic        rd_en;
	logic        wr_en;
	logic [4:0]  reg_num;
	logic [2:0]  sel;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        rvalid;
	logic        rhit;
	logic [2:0]  kh;
	logic [2:0]  ku;
	logic [2:0]  kz;
	logic [2:0]  m_kh;
	logic [2:0]  m_ku;
	logic [2:0]  m_kz;
	logic [31:0] d;
	logic [4:0]  rn;
	logic [2:0]  sl;
	int          num_errors;
	int          comparisons;

	csw_bank #(
		.CORE_FAMILY_KIND     (FAM),
		.CORE_RELEASE_LEVEL   (REL),
		.COMPACT_CODE_RELEASE (CMP)
	) u_csw_bank (
		.clk_sys                      (clk_sys),
		.reset_n                      (reset_n),
		.clk_en                       (clk_en),
		.cp0_rd_en                    (rd_en),
		.cp0_wr_en                    (wr_en),
		.cp0_reg_num                  (reg_num),
		.cp0_sel                      (sel),
		.cp0_wdata                    (wdata),
		.cp0_rdata                    (rdata),
		.cp0_rvalid                   (rvalid),
		.cp0_rhit                     (rhit),
		.kernel_high_seg_cacheability (kh),
		.user_seg_cacheability        (ku),
		.kernel_seg_zero_policy       (kz)
	);

	always #50 clk_sys = ~clk_sys;

	function automatic logic [31:0] expd(input logic [4:0] r,
		input logic [2:0] s);
		if (r == 5'h10 && s == 3'h0) begin
			return {1'b1, m_kh, m_ku, 4'h1, 4'h0, 1'b1, 1'b0, FAM, REL,
				3'h3, 4'h0, m_kz};
		end
		if (r == 5'h10 && s == 3'h3) begin
			return {9'h0, 2'h1, CMP, 2'h3, 2'h1, 2'h3, 3'h0, 1'b0, 1'b0,
				2'h3, 1'b0, 1'b1, 2'h0, 1'b0};
		end
		return 32'h0;
	endfunction : expd

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// called at a falling edge; the request is taken at the rising edge and
	// stays up until the next call replaces it, so no strobe is assigned
	// twice in one time step
	task automatic xfer(input logic r, input logic w, input logic [4:0] a,
		input logic [2:0] s, input logic [31:0] wd);
		rd_en = r;
		wr_en = w;
		reg_num = a;
		sel = s;
		// software keeps the reserved bits of word0 at zero when writing
		wdata = (a == 5'h10 && s == 3'h0)
			? (wd & ~32'h018e0078) : wd;
		@(negedge clk_sys);
		if (w && clk_en && a == 5'h10 && s == 3'h0) begin
			m_kh = wd[30:28];
			m_ku = wd[27:25];
			m_kz = wd[2:0];
		end
	endtask : xfer

	// the expectation is taken before the edge: a same-cycle write is
	// not yet visible to the read
	task automatic rd_chk(input logic [4:0] a, input logic [2:0] s,
		input logic w, input logic [31:0] wd);
		logic [31:0] e;
		logic        h;
		e = expd(a, s);
		h = a == 5'h10 && (s == 3'h0 || s == 3'h3);
		xfer(1'b1, w, a, s, wd);
		chk("rdata", rdata, e);
		chk("rhit", {31'h0, rhit}, {31'h0, h});
		chk("rvalid", {31'h0, rvalid}, 32'h1);
		chk("fields", {kh, ku, kz}, {m_kh, m_ku, m_kz});
	endtask : rd_chk

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	initial begin
		#(2000 * 100);
		num_errors++;
		stop_test();
	end

	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		clk_en = 1'b1;
		rd_en = 1'b0;
		wr_en = 1'b0;
		reg_num = 5'h0;
		sel = 3'h0;
		wdata = 32'h0;
		m_kh = 3'h2;
		m_ku = 3'h2;
		m_kz = 3'h2;
		num_errors = 0;
		comparisons = 0;
		void'($urandom(31320));
		repeat (6) @(negedge clk_sys);
		reset_n = 1'b1;
		chk("reset fields", {kh, ku, kz}, 9'h092);
		xfer(1'b1, 1'b0, 5'h10, 3'h0, 32'h0);
		d = rdata;
		chk("next word", d[31], 1'b1);
		chk("khigh", d[30:28], 3'h2);
		chk("user", d[27:25], 3'h2);
		chk("kzero", d[2:0], 3'h2);
		chk("reserved", d & 32'h018e0078, 32'h0);
		chk("custom", d[22], 1'b0);
		chk("simple be", d[21], 1'b1);
		chk("muldiv", d[20], 1'b0);
		chk("dual sram", d[16], 1'b1);
		chk("family", {d[14:13], d[12:10]}, {FAM, REL});
		chk("mapping", d[9:7], 3'h3);
		xfer(1'b1, 1'b0, 5'h10, 3'h3, 32'h0);
		d = rdata;
		chk("w3 top", d[31:23], 9'h0);
		chk("prio width", d[22:21], 2'h1);
		chk("mcu ext", d[17], 1'b1);
		chk("exc set", d[16], 1'b1);
		chk("isa", d[15:14], 2'h1);
		chk("user local", d[13], 1'b1);
		chk("inhibit", d[12], 1'b1);
		chk("ext irq", d[6], 1'b1);
		chk("vec irq", d[5], 1'b1);
		chk("small page", d[4], 1'b0);
		chk("map trace", {d[3], d[8], d[0]}, 3'h4);
		$display("test reset values done");
		// corner: all ones to word0 and to word3, then random traffic
		rd_chk(5'h10, 3'h0, 1'b1, 32'hffffffff);
		rd_chk(5'h10, 3'h3, 1'b1, 32'hffffffff);
		// corner: a write alone, then a read of what it stored
		xfer(1'b0, 1'b1, 5'h10, 3'h0, $urandom);
		chk("write only", {kh, ku, kz}, {m_kh, m_ku, m_kz});
		rd_chk(5'h10, 3'h0, 1'b0, 32'h0);
		for (int i = 0; i < 40; i++) begin
			rn = ($urandom % 3 == 0) ? 5'($urandom) : 5'h10;
			sl = ($urandom % 2 == 0) ? 3'($urandom) : 3'h0;
			rd_chk(rn, sl, 1'($urandom), $urandom);
			rd_chk(5'h10, 3'h0, 1'b0, $urandom);
		end
		$display("test random access done");
		clk_en = 1'b0;
		xfer(1'b1, 1'b1, 5'h10, 3'h0, 32'h0);
		// the last read left rvalid high and a low enable freezes it there
		chk("frozen rvalid", {31'h0, rvalid}, 32'h1);
		chk("frozen rdata", rdata, expd(5'h10, 3'h0));
		chk("frozen fields", {kh, ku, kz}, {m_kh, m_ku, m_kz});
		clk_en = 1'b1;
		rd_chk(5'h10, 3'h0, 1'b0, 32'h0);
		$display("test clock enable done");
		xfer(1'b0, 1'b1, 5'h10, 3'h0, 32'h0);
		clk_en = 1'b0;
		reset_n = 1'b0;
		@(negedge clk_sys);
		reset_n = 1'b1;
		clk_en = 1'b1;
		m_kh = 3'h2;
		m_ku = 3'h2;
		m_kz = 3'h2;
		chk("rst fields", {kh, ku, kz}, 9'h092);
		chk("rst rdata", rdata, 32'h0);
		chk("rst rvalid", {31'h0, rvalid}, 32'h0);
		rd_chk(5'h10, 3'h0, 1'b0, 32'h0);
		$display("test mid-run reset done");
		stop_test();
	end
endmodule : testbench
